// ### pkg/adc_ctrl_pkg.sv
// shared constants, types and carriers of the converter control block
package adc_ctrl_pkg;
    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACQ_TIME_NS = 400;
    // least time, so round up to whole cycles
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam logic [3:0] ACQ_LAST = 4'(ACQ_CYCLES - 1);
    localparam int IMPULSE_RATE_KSPS = 444;

    // ********************************************************
    // result word
    // ********************************************************
    localparam int RES_W = 16;
    localparam logic [15:0] SAR_FIRST = 16'h8000;
    localparam logic [15:0] SAR_LAST = 16'h0001;
    localparam logic [15:0] TWOS_FLIP = 16'h8000;

    // ********************************************************
    // register map
    // ********************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam logic [3:0] REG_RESULT = 4'hc;
    localparam int CTRL_MODE_LSB = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOWPWR_BIT = 1;
    localparam int ST_PDOWN_BIT = 2;
    localparam int ST_ARMED_BIT = 3;
    localparam int ST_LEVEL_LSB = 4;

    typedef enum logic [1:0] {
        MODE_WARP,
        MODE_NORMAL,
        MODE_IMPULSE
    } mode_t;
    localparam mode_t CTRL_MODE_RESET = MODE_NORMAL;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic select_n;
        logic read_n;
    } host_rd_t;
endpackage

// ### logic/sar_core.sv
// successive approximation register, one bit decision per clock
`timescale 1ns/1ps
module sar_core (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic comp_i,
    output logic [adc_ctrl_pkg::RES_W-1:0] dac_code_o,
    output logic [adc_ctrl_pkg::RES_W-1:0] result_o,
    output logic done_o
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic active;
        logic done;
        logic [RES_W-1:0] mask;
        logic [RES_W-1:0] code;
    } sar_state_t;

    sar_state_t s;
    sar_state_t next_s;
    logic [RES_W-1:0] kept;

    // ********************************************************
    // decision sequence
    // ********************************************************
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        kept = comp_i ? s.code : (s.code & ~s.mask);
        if (!s.active) begin
            // a start while active is not seen: no restart mid way
            if (start_i) begin
                next_s.active = 1'b1;
                next_s.mask = SAR_FIRST;
                next_s.code = SAR_FIRST;
            end
        end else if (s.mask == SAR_LAST) begin
            // over-range keeps every trial bit, giving all ones
            next_s.code = kept;
            next_s.active = 1'b0;
            next_s.done = 1'b1;
        end else begin
            next_s.mask = s.mask >> 1;
            next_s.code = kept | (s.mask >> 1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dac_code_o = s.code;
    assign result_o = s.code;
    assign done_o = s.done;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_sar_length: assert property ((start_i && !s.active) |-> ##17 done_o)
        else $error("decision sequence not 16 bits long");
    a_sar_fullscale: assert property ((start_i && !s.active) ##1 comp_i[*8]
        ##1 comp_i[*8] |=> (result_o == 16'hffff))
        else $error("full scale did not give all ones");
endmodule

// ### logic/pair_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [1:0] level_o
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] count;
    } buf_state_t;

    buf_state_t s;
    buf_state_t next_s;
    logic push;
    logic pop;

    assign in_ready_o = (s.count != 2'h2);
    assign out_valid_o = (s.count != 2'h0);
    assign out_data_o = s.mem[0];
    assign level_o = s.count;

    always_comb begin
        next_s = s;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (pop) begin
            next_s.mem[0] = s.mem[1];
            next_s.count = s.count - 2'h1;
        end
        if (push) begin
            next_s.mem[next_s.count[0]] = in_data_i;
            next_s.count = next_s.count + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ### logic/adc_conv_ctrl.sv
// conversion control and parallel result read of a 16-bit converter
`timescale 1ns/1ps
// Notes on behaviour
// - a start launches a conversion that runs to its end, power-down or not
// - start works whatever select and read are doing
// - low-power mode: start held low restarts after acquisition, repeatedly
// - self-restart only in low-power mode; other modes need a fresh start
// - self-running rate (28 cycles, near 893 kSPS) is about twice the 444 kSPS low-power rate limit
// - low-power mode drops power after each conversion, through acquisition
// - host reads keep working during acquisition
// - select or read high puts the data pins in high impedance
// - read low with select low drives the result onto the bus
// - coding input picks straight binary or twos complement
// - interface-select low enables the parallel bus; serial shares the pins
// - reads after or during next conversion see the previous result
// - over-range gives all ones or 7fff; midscale 8000 or 0000
// - low-power mode has a lower rate limit, saving power between samples
module adc_conv_ctrl (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic conversion_start_n_i,
    input wire logic power_down_in_i,
    input wire logic output_coding_select_i,
    input wire logic interface_select_i,
    input wire adc_ctrl_pkg::host_rd_t host_rd_i,
    input wire logic comp_i,
    output logic [adc_ctrl_pkg::RES_W-1:0] dac_code_o,
    output logic busy_o,
    output logic low_power_o,
    output logic [adc_ctrl_pkg::RES_W-1:0] data_o,
    output logic [adc_ctrl_pkg::RES_W-1:0] data_oe_o,
    input wire adc_ctrl_pkg::reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o
);
    import adc_ctrl_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_HOLD,
        ST_PDOWN
    } conv_state_t;

    typedef struct packed {
        conv_state_t st;
        mode_t mode;
        logic start_prev;
        logic armed;
        logic [3:0] acq_cnt;
        logic rd_prev;
        logic [RES_W-1:0] out_word;
        logic [RES_W-1:0] conv_count;
        logic [31:0] rdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic start_fell;
    logic sar_start;
    logic sar_done;
    logic [RES_W-1:0] sar_result;
    logic push_valid;
    logic push_ready;
    logic head_valid;
    logic [RES_W-1:0] head_word;
    logic [1:0] level;
    logic rd_active;
    logic pop;
    logic [RES_W-1:0] coded;
    logic [31:0] rd_value;

    // ********************************************************
    // submodules
    // ********************************************************
    sar_core u_sar (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(sar_start),
        .comp_i(comp_i),
        .dac_code_o(dac_code_o),
        .result_o(sar_result),
        .done_o(sar_done)
    );

    // a full buffer holds busy high instead of dropping a word
    pair_buffer #(
        .W(RES_W)
    ) u_buf (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(sar_result),
        .out_valid_o(head_valid),
        .out_ready_i(pop),
        .out_data_o(head_word),
        .level_o(level)
    );

    // ********************************************************
    // host read side
    // ********************************************************
    // select and read are never looked at by the conversion sequence
    assign rd_active = !host_rd_i.select_n && !host_rd_i.read_n
                       && !interface_select_i;
    assign data_oe_o = {RES_W{rd_active}};
    assign data_o = s.out_word;
    // a word is consumed when its read strobe ends
    assign pop = s.rd_prev && !rd_active && head_valid;
    assign coded = output_coding_select_i ? head_word
                   : (head_word ^ TWOS_FLIP);

    assign start_fell = s.start_prev && !conversion_start_n_i;
    assign busy_o = (s.st == ST_CONV) || (s.st == ST_HOLD);
    assign low_power_o = (s.st == ST_PDOWN)
                         || ((s.mode == MODE_IMPULSE) && !busy_o);
    assign push_valid = ((s.st == ST_CONV) && sar_done) || (s.st == ST_HOLD);

    // ********************************************************
    // register read mux
    // ********************************************************
    always_comb begin
        rd_value = 32'h0000_0000;
        case (reg_req_i.addr)
            REG_CTRL: begin
                rd_value[CTRL_MODE_LSB +: 2] = s.mode;
            end
            REG_STATUS: begin
                rd_value[ST_BUSY_BIT] = busy_o;
                rd_value[ST_LOWPWR_BIT] = low_power_o;
                rd_value[ST_PDOWN_BIT] = (s.st == ST_PDOWN);
                rd_value[ST_ARMED_BIT] = s.armed;
                rd_value[ST_LEVEL_LSB +: 2] = level;
            end
            REG_COUNT: begin
                rd_value[RES_W-1:0] = s.conv_count;
            end
            REG_RESULT: begin
                rd_value[RES_W-1:0] = s.out_word;
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // ********************************************************
    // conversion sequence
    // ********************************************************
    always_comb begin
        next_s = s;
        sar_start = 1'b0;
        next_s.start_prev = conversion_start_n_i;
        next_s.rd_prev = rd_active;
        if (head_valid) begin
            next_s.out_word = coded;
        end
        next_s.rdata = reg_req_i.rd ? rd_value : 32'h0000_0000;
        if (reg_req_i.wr && (reg_req_i.addr == REG_CTRL)) begin
            // code 3 names no mode and is dropped
            if (reg_req_i.wdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
                next_s.mode = mode_t'(reg_req_i.wdata[CTRL_MODE_LSB +: 2]);
            end
        end
        case (s.st)
            ST_IDLE: begin
                if (power_down_in_i) begin
                    next_s.st = ST_PDOWN;
                end else if (start_fell) begin
                    next_s.armed = 1'b1;
                    sar_start = 1'b1;
                    next_s.st = ST_CONV;
                end else if ((s.mode == MODE_IMPULSE) && s.armed
                             && !conversion_start_n_i) begin
                    next_s.acq_cnt = 4'h0;
                    next_s.st = ST_ACQ;
                end
            end
            ST_ACQ: begin
                // no rate limiter: the self-run may beat the rated speed
                if (conversion_start_n_i || (s.mode != MODE_IMPULSE)) begin
                    next_s.st = ST_IDLE;
                end else if (power_down_in_i) begin
                    next_s.st = ST_PDOWN;
                end else if (s.acq_cnt == ACQ_LAST) begin
                    sar_start = 1'b1;
                    next_s.st = ST_CONV;
                end else begin
                    next_s.acq_cnt = s.acq_cnt + 4'h1;
                end
            end
            ST_CONV: begin
                // power-down and new starts are not looked at here
                if (sar_done) begin
                    next_s.st = push_ready ? ST_IDLE : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (push_ready) begin
                    next_s.st = ST_IDLE;
                end
            end
            ST_PDOWN: begin
                if (!power_down_in_i) begin
                    next_s.st = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        if (push_valid && push_ready) begin
            next_s.conv_count = s.conv_count + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s <= '{st: ST_IDLE, mode: CTRL_MODE_RESET, start_prev: 1'b1,
                   armed: 1'b0, acq_cnt: 4'h0, rd_prev: 1'b0,
                   out_word: 16'h0000, conv_count: 16'h0000,
                   rdata: 32'h0000_0000};
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_start_gives_busy: assert property ((s.st == ST_IDLE) && start_fell
        && !power_down_in_i |=> busy_o)
        else $error("accepted start did not raise busy");
    a_conv_not_aborted: assert property ($rose(busy_o) |-> busy_o[*8]
        ##1 busy_o[*8])
        else $error("conversion ended early");
    a_conv_ends_bounded: assert property ($rose(busy_o) && push_ready
        |-> ##[16:17] !busy_o)
        else $error("busy did not fall after sixteen decisions");
    a_start_ignored: assert property ((s.st == ST_CONV) && !sar_done
        |=> (s.st == ST_CONV) || (s.st == ST_HOLD))
        else $error("conversion left before its end");
    a_auto_restart: assert property ((s.st == ST_ACQ)
        && (s.acq_cnt == ACQ_LAST) && !conversion_start_n_i
        && !power_down_in_i && (s.mode == MODE_IMPULSE) |=> busy_o)
        else $error("self-restart did not start");
    a_no_auto_other: assert property ((s.st == ST_IDLE)
        && (s.mode != MODE_IMPULSE) && !start_fell |=> !busy_o)
        else $error("conversion began without a start edge");
    a_bus_released: assert property ((host_rd_i.select_n
        || host_rd_i.read_n || interface_select_i) |-> (data_oe_o == '0))
        else $error("data pins driven while deselected");
    a_coding_path: assert property (head_valid ##1 !$past(pop)
        |-> (s.out_word == ($past(output_coding_select_i)
        ? $past(head_word) : ($past(head_word) ^ TWOS_FLIP))))
        else $error("output coding wrong");
    a_low_power_acq: assert property ((s.st == ST_ACQ) |-> low_power_o)
        else $error("acquisition not in low power");

    c_self_run: cover property ((s.st == ST_ACQ) ##[1:20] busy_o);
    c_read_in_conv: cover property (busy_o && rd_active && head_valid);
    c_buffer_full: cover property (s.st == ST_HOLD);
    c_power_down: cover property (s.st == ST_PDOWN);
endmodule

// ### dv/analog_host_model.sv
// far-side model: analog source with comparator, and the shared data wire
`timescale 1ns/1ps
module analog_host_model (
    input wire logic clk_sys_i,
    input wire logic busy_i,
    input wire logic [15:0] level_i,
    input wire logic [15:0] dac_code_i,
    input wire logic [15:0] data_i,
    input wire logic [15:0] data_oe_i,
    output logic comp_o,
    output logic [15:0] bus_o
);
    logic [15:0] held = 16'h0000;
    logic [15:0] last = 16'h0000;

    // ********************
    // analog side
    // ********************
    // the input may move only while busy is low, so it has settled by then
    always @(posedge clk_sys_i) begin
        if (busy_i !== 1'b1) begin
            held <= level_i;
        end
    end
    assign comp_o = (held >= dac_code_i);

    // ********************
    // bus wire
    // ********************
    // released pins show the inverse of the last level, never a stale value
    assign bus_o = (data_i & data_oe_i) | (~last & ~data_oe_i);
    always @(posedge clk_sys_i) begin
        last <= bus_o;
    end
endmodule

// ### dv/test_adc_conv_ctrl.sv
// self-checking testbench of the converter control block
`timescale 1ns/1ps
module test_adc_conv_ctrl;
    import adc_ctrl_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start_n = 1'b1;
    logic pdown = 1'b0;
    logic coding = 1'b1;
    logic iface = 1'b0;
    host_rd_t host_rd = 2'b11;
    reg_req_t req = '0;
    logic [15:0] level = 16'h0000;
    logic comp, busy, low_power;
    logic [15:0] dac_code, data, data_oe, bus;
    logic [31:0] rdata;
    int bad_count = 0;
    int n_compared = 0;
    int run = 0;
    int width = 0;
    int pushes = 0;
    logic [31:0] rdata_q;

    adc_conv_ctrl uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .conversion_start_n_i(start_n), .power_down_in_i(pdown),
        .output_coding_select_i(coding), .interface_select_i(iface),
        .host_rd_i(host_rd), .comp_i(comp), .dac_code_o(dac_code),
        .busy_o(busy), .low_power_o(low_power), .data_o(data),
        .data_oe_o(data_oe), .reg_req_i(req), .reg_rdata_o(rdata));
    analog_host_model host (.clk_sys_i(clk_sys_i), .busy_i(busy),
        .level_i(level), .dac_code_i(dac_code), .data_i(data),
        .data_oe_i(data_oe), .comp_o(comp), .bus_o(bus));

    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // busy length and number of finished conversions
    always @(posedge clk_sys_i) begin
        run <= (busy === 1'b1) ? run + 1 : 0;
        if (busy === 1'b0 && run != 0) begin
            width <= run;
            pushes <= pushes + 1;
        end
    end

    // ********************
    // shared tasks
    // ********************
    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req <= '0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        d = rdata;
    endtask

    task automatic wait_busy(input logic v, input int limit);
        int n;
        n = 0;
        while (busy !== v && n < limit) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
    endtask

    // short read, well inside the first half of any conversion
    task automatic host_read(output logic [15:0] d);
        @(posedge clk_sys_i);
        host_rd <= 2'b00;
        @(posedge clk_sys_i);
        #1;
        d = bus;
        chk("output enable", 32'h0000ffff, data_oe);
        @(posedge clk_sys_i);
        host_rd <= 2'b11;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic convert(input logic [15:0] lv, input logic pd,
                           input logic mid, input logic [15:0] prev);
        logic [15:0] d;
        @(posedge clk_sys_i);
        level <= lv;
        @(posedge clk_sys_i);
        start_n <= 1'b0;
        wait_busy(1'b1, 8);
        chk("busy rise", 1, busy);
        if (mid) begin
            host_read(d);
            chk("read during conversion", prev, d);
        end
        @(posedge clk_sys_i);
        pdown <= pd;
        wait_busy(1'b0, 60);
        @(posedge clk_sys_i);
        #1;
        chk("busy width", 17, width);
        @(posedge clk_sys_i);
        start_n <= 1'b1;
        pdown <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic s_regs();
        reg_rd(REG_CTRL, rdata_q);
        chk("ctrl reset", 32'(CTRL_MODE_RESET), rdata_q);
        reg_wr(REG_CTRL, 32'h3);
        reg_rd(REG_CTRL, rdata_q);
        chk("ctrl bad mode", 32'(CTRL_MODE_RESET), rdata_q);
        reg_rd(4'h2, rdata_q);
        chk("unmapped", 32'h0, rdata_q);
    endtask

    task automatic s_codes();
        logic [15:0] lv [3] = '{16'hffff, 16'h8000, 16'h1234};
        logic [15:0] d;
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 2; c++) begin
                coding <= c[0];
                convert(lv[i], c[0], 1'b0, 16'h0000);
                host_read(d);
                chk("coded result", lv[i] ^ (c[0] ? 16'h0 : TWOS_FLIP), d);
            end
        end
    endtask

    task automatic s_hiz();
        host_rd_t combos [3] = '{2'b10, 2'b01, 2'b11};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_i);
            host_rd <= combos[i];
            @(posedge clk_sys_i);
            #1;
            chk("pins released", 32'h0, data_oe);
        end
        @(posedge clk_sys_i);
        host_rd <= 2'b00;
        iface <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk("serial selected", 32'h0, data_oe);
        @(posedge clk_sys_i);
        host_rd <= 2'b11;
        iface <= 1'b0;
    endtask

    // a second start mid-conversion and a held start must not convert again
    task automatic s_no_restart(input mode_t m);
        int p;
        logic [15:0] d;
        reg_wr(REG_CTRL, 32'(m));
        @(posedge clk_sys_i);
        level <= 16'h5a5a;
        start_n <= 1'b0;
        wait_busy(1'b1, 8);
        @(posedge clk_sys_i);
        start_n <= 1'b1;
        @(posedge clk_sys_i);
        start_n <= 1'b0;
        wait_busy(1'b0, 60);
        @(posedge clk_sys_i);
        #1;
        p = pushes;
        chk("no queued start", 17, width);
        repeat (30) @(posedge clk_sys_i);
        #1;
        chk("no self restart", 32'(p), 32'(pushes));
        start_n <= 1'b1;
        host_read(d);
        chk("held start result", 16'h5a5a, d);
    endtask

    task automatic s_during();
        logic [15:0] d;
        convert(16'h1111, 1'b0, 1'b0, 16'h0000);
        convert(16'h2222, 1'b0, 1'b1, 16'h1111);
        host_read(d);
        chk("read after conversion", 16'h2222, d);
        reg_rd(REG_RESULT, rdata_q);
        chk("result register", 32'h0000_2222, rdata_q);
    endtask

    task automatic s_impulse();
        logic [15:0] d;
        reg_wr(REG_CTRL, 32'h2);
        @(posedge clk_sys_i);
        level <= 16'h0abc;
        @(posedge clk_sys_i);
        #1;
        chk("low power idle", 1, low_power);
        start_n <= 1'b0;
        // no least gap is demanded: the self-run may go about twice the rated speed
        for (int k = 0; k < 3; k++) begin
            wait_busy(1'b1, 30);
            chk("self restart", 1, busy);
            chk("power while busy", 0, low_power);
            wait_busy(1'b0, 40);
            chk("power saved", 1, low_power);
            host_read(d);
            chk("acquisition read", 16'h0abc, d);
        end
        // stall the reader: buffer fills, the third result waits in busy
        for (int k = 0; k < 2; k++) begin
            wait_busy(1'b1, 30);
            wait_busy(1'b0, 40);
        end
        wait_busy(1'b1, 30);
        repeat (40) @(posedge clk_sys_i);
        #1;
        chk("busy while full", 1, busy);
        start_n <= 1'b1;
        reg_rd(REG_STATUS, rdata_q);
        chk("level full", 32'h2, 32'(rdata_q[5:4]));
        chk("status full", 32'h0000_0029, rdata_q);
        for (int k = 0; k < 3; k++) begin
            host_read(d);
            chk("drained word", 16'h0abc, d);
        end
        chk("busy drained", 0, busy);
        reg_rd(REG_STATUS, rdata_q);
        chk("level empty", 32'h0, 32'(rdata_q[5:4]));
        reg_rd(REG_COUNT, rdata_q);
        chk("result count", 32'(pushes[15:0]), rdata_q);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk("busy after reset", 0, busy);
        s_regs();
        s_codes();
        s_hiz();
        s_no_restart(MODE_WARP);
        s_no_restart(MODE_NORMAL);
        s_during();
        s_impulse();
        complete_run();
    end
endmodule
